// ---- hw/sdtc_defs.vh ----
/*
  register offsets, field positions, reset values and code points of the
  sd transfer configuration block. assumes byte addresses on a 8-bit address port.
*/
`ifndef SDTC_DEFS_VH
`define SDTC_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SDTC_OFS_SYS_ADDR 8'h00
`define SDTC_OFS_BLK_LEN 8'h04
`define SDTC_OFS_XFER_MODE 8'h0c
`define SDTC_OFS_STATUS 8'h24
`define SDTC_OFS_HOST_CTRL 8'h28
`define SDTC_OFS_CLK_CTRL 8'h2c
`define SDTC_OFS_MMC_CTRL 8'h30

// ----------------------------------------
// field positions
// ----------------------------------------
`define SDTC_BLK_BYTES_MSB 11
`define SDTC_BOUND_LSB 12
`define SDTC_BOUND_MSB 14
`define SDTC_HC_NARROW 1
`define SDTC_HC_FAST 2
`define SDTC_HC_SEL_LSB 3
`define SDTC_HC_SEL_MSB 4
`define SDTC_HC_WIDE 5
`define SDTC_XM_ENGINE 0
`define SDTC_XM_START 1
`define SDTC_CC_CLK_EN 2
`define SDTC_CC_DIV_LSB 8
`define SDTC_CC_DIV_MSB 15
`define SDTC_MC_DDR 3

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define SDTC_BLK_LEN_RST 16'h0200
`define SDTC_HOST_CTRL_RST 8'h00
`define SDTC_BLK_BYTES_MAX 12'h200
`define SDTC_BOUND_BASE_BIT 12

// ----------------------------------------
// engine select codes
// ----------------------------------------
`define SDTC_SEL_SDMA 2'h0
`define SDTC_SEL_ADMA32 2'h2

`endif

// ---- hw/sdtc_top.v ----
/*
  sd transfer configuration: block length and sdma boundary register, host
  control byte, transfer sequencing toward the card data lines and an 8-word fifo.
  assumes a single-cycle register port and a card clock arriving as a plain pin.
*/
// Strobed register access and the placing of the registers were left to the implementer.
// Operation
// R1: block length accepts 1 to 512 bytes
// R2: block length writes ignored while busy
// R3: sdma pauses at boundary, raises dma interrupt
// R4: boundary code doubles buffer, 4k to 512k
// R5: code 0: low 12 offset, upper 20
// R6: boundary pausing only with engine enabled
// R7: narrow bit selects 1 or 4 lanes
// R8: wide bit forces 8 lanes, ignores narrow
// R9: wide clear: width from narrow bit
// R10: fast timing launches rising, else falling edge
// R11: fast timing only when ddr clear
// R12: software sets nonzero divider for fast timing
// R13: software gates card clock around fast toggle
// R14: software checks fast capability before enabling
// R15: select 0 sdma, 2 adma32, others reserved
// R16: selected engine used only when enabled
// R17: new system address resumes paused sdma
`timescale 1ns/1ps
`include "sdtc_defs.vh"

// ----------------------------------------
// fifo
// ----------------------------------------
module sdtc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire [WIDTH-1:0] wr_data_in,
  input wire wr_valid_in,
  output wire wr_ready_out,
  output wire [WIDTH-1:0] rd_data_out,
  output wire rd_valid_out,
  input wire rd_ready_in
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0] wptr_reg;
  reg [AW-1:0] rptr_reg;
  reg [AW:0] count_reg;
  wire do_wr;
  wire do_rd;

  assign wr_ready_out = (count_reg != DEPTH[AW:0]);
  assign rd_valid_out = (count_reg != {(AW+1){1'b0}});
  assign rd_data_out = mem_reg[rptr_reg];
  assign do_wr = wr_valid_in & wr_ready_out;
  assign do_rd = rd_ready_in & rd_valid_out;

  always @(posedge sys_clk_in)
  begin
    if (do_wr)
    begin
      mem_reg[wptr_reg] <= wr_data_in;
    end
  end

  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wptr_reg <= {AW{1'b0}};
      rptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wptr_reg <= wptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_rd)
      begin
        rptr_reg <= rptr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_wr && !do_rd)
      begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end
      else if (do_rd && !do_wr)
      begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

// ----------------------------------------
// top
// ----------------------------------------
module sdtc_top (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  input wire [7:0] mem_data_in,
  input wire mem_valid_in,
  output reg mem_ready_out,
  input wire sd_clk_in,
  output reg [7:0] dat_out,
  output reg [7:0] dat_oe_n_out,
  output reg dma_irq_out,
  output reg card_clock_enable_out,
  output reg [7:0] clock_divider_out,
  output reg ddr_mode_out
);
  reg [31:0] system_address_reg;
  reg [15:0] block_length_and_dma_boundary_reg;
  reg [7:0] host_bus_control_byte_reg;
  reg [1:0] transfer_mode_reg;
  reg [15:0] card_clock_control_reg;
  reg [3:0] mmc_control_reg;
  reg busy_reg;
  reg paused_reg;
  reg [11:0] remain_reg;
  reg [2:0] sclk_sync_reg;
  reg [7:0] shift_reg;
  reg [3:0] bits_left_reg;
  reg [3:0] fill_reg;

  wire wr_sel_addr = reg_wr_in && (reg_addr_in == `SDTC_OFS_SYS_ADDR);
  wire wr_sel_blk = reg_wr_in && (reg_addr_in == `SDTC_OFS_BLK_LEN);
  wire wr_sel_xm = reg_wr_in && (reg_addr_in == `SDTC_OFS_XFER_MODE);
  wire wr_sel_hc = reg_wr_in && (reg_addr_in == `SDTC_OFS_HOST_CTRL);
  wire wr_sel_cc = reg_wr_in && (reg_addr_in == `SDTC_OFS_CLK_CTRL);
  wire wr_sel_mc = reg_wr_in && (reg_addr_in == `SDTC_OFS_MMC_CTRL);

  wire [11:0] blk_bytes = block_length_and_dma_boundary_reg[`SDTC_BLK_BYTES_MSB:0];
  wire [2:0] bound_code = block_length_and_dma_boundary_reg[`SDTC_BOUND_MSB:`SDTC_BOUND_LSB];
  wire [11:0] new_bytes = reg_wdata_in[`SDTC_BLK_BYTES_MSB:0];
  wire engine_en = transfer_mode_reg[`SDTC_XM_ENGINE];
  wire [1:0] engine_sel = host_bus_control_byte_reg[`SDTC_HC_SEL_MSB:`SDTC_HC_SEL_LSB];
  wire sdma_active = engine_en && (engine_sel == `SDTC_SEL_SDMA); // [R15] [R16] [R6]
  wire adma_active = engine_en && (engine_sel == `SDTC_SEL_ADMA32); // [R15] [R16]
  wire dma_active = sdma_active || adma_active;
  wire wide = host_bus_control_byte_reg[`SDTC_HC_WIDE];
  wire narrow4 = host_bus_control_byte_reg[`SDTC_HC_NARROW];
  wire fast = host_bus_control_byte_reg[`SDTC_HC_FAST] && !mmc_control_reg[`SDTC_MC_DDR]; // [R11]

  // boundary mask: 4k shifted left by the code; a carry out of the offset bits
  // means the next byte would land in a new buffer
  wire [31:0] bound_mask = (32'h0000_1000 << bound_code) - 32'h0000_0001; // [R4]
  wire [31:0] addr_next = system_address_reg + 32'h0000_0001;
  wire hit_bound = ((addr_next & bound_mask) == 32'h0000_0000); // [R5]

  // edges of the synchronised card clock; the first stage feeds only the second
  wire sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
  wire sclk_fall = !sclk_sync_reg[1] && sclk_sync_reg[2];
  wire launch = fast ? sclk_rise : sclk_fall; // [R10]

  wire fifo_wr_ready;
  wire [7:0] fifo_rd_data;
  wire fifo_rd_valid;
  wire take_mem = mem_valid_in && mem_ready_out;
  wire load_shift = launch && (bits_left_reg == 4'h0) && fifo_rd_valid;

  // lanes per launch: 8 when wide, else 4 or 1 from the narrow bit
  wire [3:0] lanes = wide ? 4'h8 : (narrow4 ? 4'h4 : 4'h1); // [R8] [R9] [R7]

  sdtc_fifo #(
    .WIDTH(8),
    .DEPTH(8),
    .AW(3)
  ) u_fifo (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .wr_data_in(mem_data_in),
    .wr_valid_in(take_mem),
    .wr_ready_out(fifo_wr_ready),
    .rd_data_out(fifo_rd_data),
    .rd_valid_out(fifo_rd_valid),
    .rd_ready_in(load_shift)
  );

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      system_address_reg <= 32'h0000_0000;
      block_length_and_dma_boundary_reg <= `SDTC_BLK_LEN_RST;
      host_bus_control_byte_reg <= `SDTC_HOST_CTRL_RST;
      transfer_mode_reg <= 2'h0;
      card_clock_control_reg <= 16'h0000;
      mmc_control_reg <= 4'h0;
    end
    else
    begin
      // a software write wins over a same-cycle hardware advance, which happens only when no write occurs
      if (wr_sel_addr)
      begin
        system_address_reg <= reg_wdata_in;
      end
      else if (take_mem && dma_active)
      begin
        system_address_reg <= addr_next;
      end
      if (wr_sel_blk && !busy_reg) // [R2]
      begin
        block_length_and_dma_boundary_reg[`SDTC_BOUND_MSB:`SDTC_BOUND_LSB] <=
          reg_wdata_in[`SDTC_BOUND_MSB:`SDTC_BOUND_LSB];
        if ((new_bytes != 12'h000) && (new_bytes <= `SDTC_BLK_BYTES_MAX)) // [R1]
        begin
          block_length_and_dma_boundary_reg[`SDTC_BLK_BYTES_MSB:0] <= new_bytes;
        end
      end
      if (wr_sel_xm)
      begin
        transfer_mode_reg <= {1'b0, reg_wdata_in[`SDTC_XM_ENGINE]};
      end
      if (wr_sel_hc)
      begin
        host_bus_control_byte_reg <= {2'h0, reg_wdata_in[5:1], 1'b0};
      end
      if (wr_sel_cc)
      begin
        card_clock_control_reg <= {reg_wdata_in[15:8], 5'h00, reg_wdata_in[2], 2'h0};
      end
      if (wr_sel_mc)
      begin
        mmc_control_reg <= {reg_wdata_in[3], 3'h0};
      end
    end
  end

  // ----------------------------------------
  // transfer sequencing
  // ----------------------------------------
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      busy_reg <= 1'b0;
      paused_reg <= 1'b0;
      remain_reg <= 12'h000;
      mem_ready_out <= 1'b0;
      dma_irq_out <= 1'b0;
      fill_reg <= 4'h0;
    end
    else
    begin
      if (!busy_reg && wr_sel_xm && reg_wdata_in[`SDTC_XM_START])
      begin
        busy_reg <= 1'b1;
        remain_reg <= blk_bytes;
      end
      else if (busy_reg && (remain_reg == 12'h000) && !fifo_rd_valid && (bits_left_reg == 4'h0))
      begin
        busy_reg <= 1'b0;
      end
      if (take_mem)
      begin
        remain_reg <= remain_reg - 12'h001;
      end
      if (take_mem && sdma_active && hit_bound && (remain_reg != 12'h001))
      begin
        paused_reg <= 1'b1; // [R3] [R6]
      end
      else if (wr_sel_addr)
      begin
        paused_reg <= 1'b0; // [R17]
      end
      dma_irq_out <= paused_reg; // [R3]
      // occupancy mirror: ready is registered, so it must fall on the edge of the accept that uses the last free slot
      fill_reg <= fill_reg + {3'h0, take_mem} - {3'h0, load_shift};
      // ready falls in the cycle after an accept if that accept ends the block or pauses
      mem_ready_out <= busy_reg && !paused_reg && fifo_wr_ready && (remain_reg != 12'h000) &&
        !(take_mem && ((remain_reg == 12'h001) || (sdma_active && hit_bound))) &&
        !(take_mem && !load_shift && (fill_reg == 4'h7));
    end
  end

  // ----------------------------------------
  // card data lanes
  // ----------------------------------------
  always @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sclk_sync_reg <= 3'h0;
      shift_reg <= 8'h00;
      bits_left_reg <= 4'h0;
      dat_out <= 8'hff;
      dat_oe_n_out <= 8'hff;
      reg_rdata_out <= 32'h0000_0000;
      card_clock_enable_out <= 1'b0;
      clock_divider_out <= 8'h00;
      ddr_mode_out <= 1'b0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sd_clk_in};
      // the loading launch drives the first slice too, so no lane bit repeats between bytes
      if (load_shift)
      begin
        shift_reg <= fifo_rd_data << lanes;
        bits_left_reg <= 4'h8 - lanes;
        dat_oe_n_out <= wide ? 8'h00 : (narrow4 ? 8'hf0 : 8'hfe); // [R7] [R8]
        dat_out <= wide ? fifo_rd_data : (narrow4 ? {4'hf, fifo_rd_data[7:4]} : {7'h7f, fifo_rd_data[7]}); // [R10]
      end
      else if (launch && (bits_left_reg != 4'h0))
      begin
        shift_reg <= shift_reg << lanes;
        bits_left_reg <= bits_left_reg - lanes;
        dat_oe_n_out <= wide ? 8'h00 : (narrow4 ? 8'hf0 : 8'hfe); // [R7] [R8]
        dat_out <= wide ? shift_reg : (narrow4 ? {4'hf, shift_reg[7:4]} : {7'h7f, shift_reg[7]}); // [R10]
      end
      else if (launch)
      begin
        dat_out <= 8'hff;
        dat_oe_n_out <= 8'hff;
      end
      card_clock_enable_out <= card_clock_control_reg[`SDTC_CC_CLK_EN];
      clock_divider_out <= card_clock_control_reg[`SDTC_CC_DIV_MSB:`SDTC_CC_DIV_LSB];
      ddr_mode_out <= mmc_control_reg[`SDTC_MC_DDR];
      // read data stand one cycle after the strobe and return to zero after
      reg_rdata_out <= 32'h0000_0000;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          `SDTC_OFS_SYS_ADDR: reg_rdata_out <= system_address_reg;
          `SDTC_OFS_BLK_LEN: reg_rdata_out <= {16'h0000, block_length_and_dma_boundary_reg};
          `SDTC_OFS_XFER_MODE: reg_rdata_out <= {30'h0, transfer_mode_reg};
          `SDTC_OFS_STATUS: reg_rdata_out <= {30'h0, paused_reg, busy_reg};
          `SDTC_OFS_HOST_CTRL: reg_rdata_out <= {24'h0, host_bus_control_byte_reg};
          `SDTC_OFS_CLK_CTRL: reg_rdata_out <= {16'h0, card_clock_control_reg};
          `SDTC_OFS_MMC_CTRL: reg_rdata_out <= {28'h0, mmc_control_reg};
          default: reg_rdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ---- testbench/sdtc_asserts.sv ----
/* port checker for sdtc_top.
   assumes one clock domain with async active-low reset; bound after the module. */
`timescale 1ns/1ps
module sdtc_asserts (
  input wire sys_clk_in,
  input wire resetn_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  input wire mem_ready_out,
  input wire [7:0] dat_oe_n_out,
  input wire dma_irq_out,
  input wire [7:0] clock_divider_out,
  input wire ddr_mode_out
);
  // ------
  // properties
  // ------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence hc_wr_rd;
    reg_wr_in && reg_addr_in == 8'h28 ##2 reg_rd_in && reg_addr_in == 8'h28;
  endsequence
  sequence resume_wr;
    dma_irq_out && reg_wr_in && reg_addr_in == 8'h00;
  endsequence
  host_readback_a: assert property (
    hc_wr_rd |=> ((reg_rdata_out ^ $past(reg_wdata_in, 3)) & 32'h3e) == 32'h0)
    else $error("host readback wrong");
  blk_range_a: assert property (
    reg_rd_in && reg_addr_in == 8'h04 |=> reg_rdata_out[11:0] != 12'h0 && reg_rdata_out[11:0] <= 12'h200)
    else $error("block length out of range");
  lane_mask_a: assert property (
    dat_oe_n_out == 8'hff || dat_oe_n_out == 8'hfe || dat_oe_n_out == 8'hf0 || dat_oe_n_out == 8'h00)
    else $error("bad lane enables");
  pause_stall_a: assert property (
    dma_irq_out && $past(dma_irq_out) |-> !mem_ready_out)
    else $error("byte taken while paused");
  resume_irq_a: assert property (
    resume_wr |-> ##2 !dma_irq_out)
    else $error("irq kept after resume");
  status_bits_a: assert property (
    reg_rd_in && reg_addr_in == 8'h24 |=> reg_rdata_out[31:2] == 30'h0)
    else $error("stray status bits");
  div_copy_a: assert property (
    reg_wr_in && reg_addr_in == 8'h2c |-> ##2 clock_divider_out == $past(reg_wdata_in[15:8], 2))
    else $error("divider copy wrong");
  ddr_copy_a: assert property (
    reg_wr_in && reg_addr_in == 8'h30 |-> ##2 ddr_mode_out == $past(reg_wdata_in[3], 2))
    else $error("ddr copy wrong");
endmodule

bind sdtc_top sdtc_asserts chk (
  .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .mem_ready_out(mem_ready_out), .dat_oe_n_out(dat_oe_n_out),
  .dma_irq_out(dma_irq_out), .clock_divider_out(clock_divider_out), .ddr_mode_out(ddr_mode_out)
);

// ---- testbench/sdtc_card_model.sv ----
/* card-side model: clocks the card within frames and collects lane data.
   assumes lane enables give the width; fast_in means fast timing with ddr off. */
`timescale 1ns/1ps
module sdtc_card_model (
  input wire run_in,
  input wire fast_in,
  input wire [7:0] dat_in,
  input wire [7:0] dat_oe_n_in,
  output reg sd_clk_out = 1'b0,
  output reg [31:0] rx_word_out = 32'h0,
  output reg phase_bad_out = 1'b0
);
  reg [7:0] acc_reg = 8'h00;
  integer bits = 0;
  // ------
  // model
  // ------
  // clock parks low between frames
  always
  begin
    #62.5;
    if (run_in || sd_clk_out)
      sd_clk_out = ~sd_clk_out;
  end
  // sample half a period after the launch edge
  always @(sd_clk_out)
    if (sd_clk_out != fast_in && dat_oe_n_in != 8'hff)
    begin
      case (dat_oe_n_in)
        8'hfe: acc_reg = {acc_reg[6:0], dat_in[0]};
        8'hf0: acc_reg = {acc_reg[3:0], dat_in[3:0]};
        default: acc_reg = dat_in;
      endcase
      bits = bits + ((dat_oe_n_in == 8'hfe) ? 1 : (dat_oe_n_in == 8'hf0) ? 4 : 8);
      if (bits >= 8)
      begin
        rx_word_out = {rx_word_out[23:0], acc_reg};
        bits = 0;
      end
    end
  // lanes may only move in the half period after a launch edge
  always @(dat_in)
    if (run_in && dat_oe_n_in != 8'hff && sd_clk_out != fast_in)
      phase_bad_out = 1'b1;
endmodule

// ---- testbench/sdtc_top_test.sv ----
/* self-checking bench for sdtc_top: register tasks and block transfers.
   assumes the card model on the lanes; the bench is the memory-side source. */
`timescale 1ns/1ps
module sdtc_top_test;
  reg sys_clk_in = 1'b0, resetn_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  reg mem_valid_in = 1'b0, run = 1'b0, fast = 1'b0;
  reg [7:0] reg_addr_in = 8'h00, mem_data_in = 8'h00, seen_oe = 8'hff;
  reg [31:0] reg_wdata_in = 32'h0, d = 32'h0;
  wire [31:0] reg_rdata_out, rx_word;
  wire [7:0] dat_out, dat_oe_n_out, clock_divider_out;
  wire mem_ready_out, sd_clk, dma_irq_out, card_clock_enable_out, ddr_mode_out, phase_bad;
  integer n_errors = 0, total_checks = 0, cycles = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  sdtc_top uut (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .mem_data_in(mem_data_in),
    .mem_valid_in(mem_valid_in), .mem_ready_out(mem_ready_out), .sd_clk_in(sd_clk), .dat_out(dat_out),
    .dat_oe_n_out(dat_oe_n_out), .dma_irq_out(dma_irq_out), .card_clock_enable_out(card_clock_enable_out),
    .clock_divider_out(clock_divider_out), .ddr_mode_out(ddr_mode_out)
  );
  sdtc_card_model card (
    .run_in(run), .fast_in(fast), .dat_in(dat_out), .dat_oe_n_in(dat_oe_n_out),
    .sd_clk_out(sd_clk), .rx_word_out(rx_word), .phase_bad_out(phase_bad)
  );
  // ------
  // tasks
  // ------
  task final_report;
    begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp)
      begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
      @(posedge sys_clk_in);
    end
  endtask
  // read data are taken at the edge closing their one-cycle window
  task rd(input [7:0] a);
    begin
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      @(posedge sys_clk_in);
      d = reg_rdata_out;
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      rd(a);
      chk(d, e);
    end
  endtask
  // the card clock stays parked for 40 cycles so a block over 8 bytes fills the fifo and is refused
  task xfer(input [7:0] hc, input ddr, input en, input [15:0] bl, input [31:0] a0,
    input pz, input [31:0] ae, input [7:0] mask);
    integer i, g, n;
    reg [7:0] b;
    reg [31:0] e;
    reg seen;
    begin
      n = bl[11:0];
      b = hc ^ bl[15:8] ^ 8'h30;
      e = 32'h0;
      seen = 1'b0;
      seen_oe = 8'hff;
      for (i = 0; i < n; i = i + 1)
        e = {e[23:0], b ^ i[7:0]};
      wr(8'h30, {28'h0, ddr, 3'h0});
      wr(8'h28, {24'h0, hc});
      chk({31'h0, ddr_mode_out}, {31'h0, ddr});
      wr(8'h00, a0);
      wr(8'h04, {16'h0, bl});
      fast <= hc[2] & ~ddr;
      wr(8'h0c, {30'h0, 1'b1, en});
      wr(8'h04, 32'h1);
      rc(8'h04, {16'h0, bl});
      i = 0;
      g = 0;
      mem_valid_in <= 1'b1;
      mem_data_in <= b;
      while ((i < n || g < 41) && g < 4000)
      begin
        @(posedge sys_clk_in);
        g = g + 1;
        if (mem_ready_out)
          i = i + 1;
        mem_data_in <= b ^ i[7:0];
        if (g == 40)
        begin
          chk(i, (n < 8) ? n : 8);
          run <= 1'b1;
        end
        if (dma_irq_out && !seen)
        begin
          seen = 1'b1;
          rc(8'h24, 32'h3);
          rc(8'h00, a0 + 32'h2);
          wr(8'h00, 32'h2000);
        end
      end
      mem_valid_in <= 1'b0;
      d = 32'h1;
      g = 0;
      while (d[0] && g < 1000)
      begin
        rd(8'h24);
        g = g + 1;
      end
      // wait past one more launch so the lanes are released before the card clock parks
      repeat (40) @(posedge sys_clk_in);
      run <= 1'b0;
      chk(rx_word, e);
      chk({24'h0, seen_oe}, {24'h0, mask});
      chk({31'h0, seen}, {31'h0, pz});
      rc(8'h00, ae);
    end
  endtask
  // ------
  // stimulus
  // ------
  always @(posedge sys_clk_in)
  begin
    cycles = cycles + 1;
    if (dat_oe_n_out != 8'hff)
      seen_oe = dat_oe_n_out;
    if (cycles == 20000)
    begin
      n_errors = n_errors + 1;
      final_report;
    end
  end
  initial
  begin
    repeat (4) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    @(posedge sys_clk_in);
    rc(8'h04, 32'h200);
    rc(8'h28, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h201);
    rc(8'h04, 32'h200);
    wr(8'h04, 32'h7001);
    rc(8'h04, 32'h7001);
    wr(8'h28, 32'h3e);
    rc(8'h28, 32'h3e);
    rc(8'h80, 32'h0);
    wr(8'h2c, 32'h504);
    @(posedge sys_clk_in);
    chk({23'h0, card_clock_enable_out, clock_divider_out}, 32'h105);
    xfer(8'h00, 1'b0, 1'b0, 16'h4, 32'h0ffe, 1'b0, 32'h0ffe, 8'hfe);
    xfer(8'h02, 1'b0, 1'b1, 16'h7004, 32'h7fffe, 1'b1, 32'h2002, 8'hf0);
    xfer(8'h02, 1'b0, 1'b1, 16'h1004, 32'h0ffe, 1'b0, 32'h1002, 8'hf0);
    xfer(8'h36, 1'b0, 1'b1, 16'hc, 32'h0ffe, 1'b0, 32'h100a, 8'h00);
    xfer(8'h0c, 1'b1, 1'b1, 16'h4, 32'h0ffe, 1'b0, 32'h0ffe, 8'hfe);
    xfer(8'h38, 1'b0, 1'b1, 16'h4, 32'h0ffe, 1'b0, 32'h0ffe, 8'h00);
    chk({31'h0, phase_bad}, 32'h0);
    final_report;
  end
endmodule
